// ===== verilog/rfs_pkg.sv
// Shared constants and carrier types for the regulator fault supervisor.
package rfs_pkg;

  // AXI4-Lite register byte addresses.
  localparam logic [7:0] RFS_ADDR_STATUS = 8'h00;  // Live and latched fault view.
  localparam logic [7:0] RFS_ADDR_CTRL   = 8'h04;  // Hiccup off-time in cycles.
  localparam logic [7:0] RFS_ADDR_COUNT  = 8'h08;  // Overcurrent event counter.

  // Decoded register index, shared by the read and write paths.
  localparam logic [1:0] RFS_IDX_STATUS = 2'h0;
  localparam logic [1:0] RFS_IDX_CTRL   = 2'h1;
  localparam logic [1:0] RFS_IDX_COUNT  = 2'h2;
  localparam logic [1:0] RFS_IDX_NONE   = 2'h3;

  // Bus responses.
  localparam logic [1:0] RFS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] RFS_RESP_SLVERR = 2'h2;

  // Overcurrent event thresholds for entering hiccup mode.
  localparam logic [5:0] RFS_OCP_LIMIT_LOW  = 6'h0f;  // 15 events, output below 2.4 V.
  localparam logic [5:0] RFS_OCP_LIMIT_HIGH = 6'h3c;  // 60 events, output above 2.4 V.

  // Reset value of the hiccup off-time, in clock cycles.
  localparam logic [15:0] RFS_HIC_LEN_RST = 16'h0400;

  // Status register field positions.
  localparam int RFS_ST_MASTER_POWER_OFF_RESET     = 0;
  localparam int RFS_ST_PG_N     = 1;
  localparam int RFS_ST_REGS_ON  = 2;
  localparam int RFS_ST_HICCUP   = 3;
  localparam int RFS_ST_LAT_DIO  = 4;
  localparam int RFS_ST_LAT_LX   = 5;
  localparam int RFS_ST_LAT_OV   = 6;
  localparam int RFS_ST_PUMP_UV  = 7;
  localparam int RFS_ST_OSC_DEF  = 8;
  localparam int RFS_ST_HIGH_UV  = 9;
  localparam int RFS_ST_HIGH_OC  = 10;
  localparam int RFS_ST_PREG_OPN = 11;
  localparam int RFS_ST_SW_OFF   = 12;

  // Analog comparator flags arriving from pins, all active high.
  typedef struct packed {
    logic ignition_enable;     // Ignition enable pin level.
    logic vin_ok;              // Input supply above its undervoltage level.
    logic preg_low;            // Pre-regulator output below 2.4 V.
    logic ea_max;              // Error amplifier output at its maximum.
    logic overcurrent_event;   // One overcurrent event per high level.
    logic hs_ilim;             // High-side current above the cycle limit.
    logic switch_node_ilim;    // High-side current above the switch-node limit.
    logic catch_diode_missing; // Missing catch diode detected.
    logic preg_ov;             // Pre-regulator overvoltage comparator.
    logic freq_set_sync_fault; // Frequency pin open or grounded.
    logic pump_ov;             // Charge pump overvoltage.
    logic pump_uv;             // Charge pump undervoltage comparator.
    logic pump_out_open;       // Pump output pin open.
    logic pump_cap_open;       // Either pump capacitor pin open.
    logic pump_cap1_gnd;       // First pump capacitor pin grounded.
    logic low_rail_uv;         // Low rail below its upper undervoltage level.
    logic low_rail_uv_low;     // Low rail below its lower undervoltage level.
    logic low_rail_oc;         // Low rail in overcurrent.
    logic high_rail_uv;        // High rail undervoltage.
    logic high_rail_oc;        // High rail overcurrent.
    logic preg_pin_open;       // Pre-regulator pin open, LDO supply pin takes over.
  } rfs_pins_t;

  // Supervisor outputs toward the regulators and pins.
  typedef struct packed {
    logic master_power_off_reset; // Shuts all regulators.
    logic power_good_reset_n;     // Power-good reset, active low.
    logic regs_on;                // All regulators allowed to run.
    logic hiccup;                 // Pre-regulator in hiccup off-time.
    logic switch_node_off;        // Ends the present switching cycle.
    logic osc_default;            // Oscillator falls back to 900 kHz.
    logic pump_undervoltage_flag; // Combined pump undervoltage.
  } rfs_ctl_t;

endpackage : rfs_pkg

// ===== verilog/rfs_supervisor.sv
// Regulator fault supervisor with an AXI4-Lite register slave.
//
// How it works
// - Hiccup after 15 events when output low.
// - Hiccup after 60 events when output high.
// - Low output, amplifier unsaturated: cut cycle only.
// - Missing diode once: latched power-off, power-good low.
// - Switch-node overcurrent: latched power-off, power-good low.
// - Forced amplifier trips latched overvoltage shutdown.
// - Bad frequency pin selects default, no fault.
// - Pump over/undervoltage: unlatched power-off reset.
// - Pump pin faults raise pump undervoltage flag.
// - Power-good low on low rail undervoltage.
// - High rail and pin faults leave power-good.
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns

module rfs_supervisor
  import rfs_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rstn,
  // Comparator flags from the analog section.
  input  wire rfs_pins_t   pins,
  // Control outputs to the regulators.
  output rfs_ctl_t         ctl,
  // AXI4-Lite write address channel.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data channel.
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response channel.
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address channel.
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data channel.
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  // All state of the block lives in one packed struct.
  typedef struct packed {
    rfs_pins_t   s1;        // First synchroniser stage.
    rfs_pins_t   s2;        // Second synchroniser stage, safe to use.
    logic        ign_d;     // Previous ignition level for edge detect.
    logic        vin_d;     // Previous input-supply level for edge detect.
    logic        ocp_d;     // Previous overcurrent level for edge detect.
    logic        lat_dio;   // Latched missing-diode fault.
    logic        lat_lx;    // Latched switch-node short fault.
    logic        lat_ov;    // Latched pre-regulator overvoltage fault.
    logic [5:0]  ocp_cnt;   // Overcurrent events in the present overload.
    logic [15:0] hic_cnt;   // Remaining hiccup off-time.
    logic [15:0] hic_len;   // Hiccup off-time, software set.
    rfs_ctl_t    ctl;       // Registered outputs.
    logic        awready;   // Write address ready.
    logic        wready;    // Write data ready.
    logic        aw_got;    // Write address held.
    logic        w_got;     // Write data held.
    logic [7:0]  waddr;     // Held write address.
    logic [31:0] wdata;     // Held write data.
    logic [3:0]  wstrb;     // Held byte strobes.
    logic        bvalid;    // Write response valid.
    logic [1:0]  bresp;     // Write response code.
    logic        arready;   // Read address ready.
    logic        rvalid;    // Read data valid.
    logic [31:0] rdata;     // Read data.
    logic [1:0]  rresp;     // Read response code.
  } rfs_state_t;

  rfs_state_t st_ff;   // Registered state.
  rfs_state_t nxt_st;  // Next state.

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Maps a byte address onto a register index; misaligned is unmapped.
  function automatic logic [1:0] reg_idx(input logic [7:0] addr);
    case (addr)
      RFS_ADDR_STATUS: reg_idx = RFS_IDX_STATUS;
      RFS_ADDR_CTRL:   reg_idx = RFS_IDX_CTRL;
      RFS_ADDR_COUNT:  reg_idx = RFS_IDX_COUNT;
      default:         reg_idx = RFS_IDX_NONE;
    endcase
  endfunction : reg_idx

  // Combinational terms shared between the fault and bus logic.
  logic        cycle_clr;   // Ignition or input supply was cycled.
  logic        ocp_rise;    // New overcurrent event.
  logic        count_ok;    // Events count toward hiccup.
  logic [5:0]  ocp_limit;   // Threshold for the present output level.
  logic [5:0]  cnt_inc;     // Counter plus one.
  logic        pump_uv_any; // Combined pump undervoltage.
  logic        master_power_off_reset_nxt;    // Next master power-off reset.
  logic        low_uv_eff;  // Low rail undervoltage as seen by power-good.
  logic [31:0] status_word; // Status register image.
  logic [15:0] ctrl_new;    // Control word after byte strobes.

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // One process computes every next value from the registered state and the inputs.
  always_comb begin
    nxt_st = st_ff;

    // Pins pass two flip-flops before any logic sees them.
    nxt_st.s1 = pins;
    nxt_st.s2 = st_ff.s1;
    nxt_st.ign_d = st_ff.s2.ignition_enable;
    nxt_st.vin_d = st_ff.s2.vin_ok;
    nxt_st.ocp_d = st_ff.s2.overcurrent_event;

    // A falling ignition or supply level is the only way out of a latch.
    cycle_clr = (st_ff.ign_d & ~st_ff.s2.ignition_enable) |
                (st_ff.vin_d & ~st_ff.s2.vin_ok);

    // Missing diode latch.
    // A single detection is enough; a new detection beats the clear.
    nxt_st.lat_dio = st_ff.s2.catch_diode_missing | (st_ff.lat_dio & ~cycle_clr);
    nxt_st.lat_lx = st_ff.s2.switch_node_ilim | (st_ff.lat_lx & ~cycle_clr);
    // Overvoltage latch.
    // A forced-high amplifier drives the output over its limit; hold it off.
    nxt_st.lat_ov = st_ff.s2.preg_ov | (st_ff.lat_ov & ~cycle_clr);

    // Pump pin faults.
    // Open or grounded pump pins all appear as pump undervoltage.
    pump_uv_any = st_ff.s2.pump_uv | st_ff.s2.pump_out_open |
                  st_ff.s2.pump_cap_open | st_ff.s2.pump_cap1_gnd;

    // Unlatched pump reset.
    // Pump faults follow the comparators and release on their own.
    master_power_off_reset_nxt = st_ff.s2.pump_ov | pump_uv_any | nxt_st.lat_dio | nxt_st.lat_lx;

    // Overcurrent event counting toward hiccup.
    ocp_rise  = st_ff.s2.overcurrent_event & ~st_ff.ocp_d;
    count_ok  = st_ff.s2.ea_max & ~st_ff.ctl.hiccup;
    cnt_inc   = st_ff.ocp_cnt + 6'h01;
    ocp_limit = st_ff.s2.preg_low ? RFS_OCP_LIMIT_LOW : RFS_OCP_LIMIT_HIGH;

    nxt_st.ctl.hiccup = st_ff.ctl.hiccup;
    if (st_ff.ctl.hiccup) begin
      // Off-time runs out, then switching resumes.
      if (st_ff.hic_cnt <= 16'h0001) begin
        nxt_st.ctl.hiccup = 1'b0;
        nxt_st.ocp_cnt = 6'h00;
      end else begin
        nxt_st.hic_cnt = st_ff.hic_cnt - 16'h0001;
      end
    end else if (ocp_rise && count_ok) begin
      if (cnt_inc >= ocp_limit) begin
        // Threshold reached: start the off-time.
        nxt_st.ctl.hiccup = 1'b1;
        nxt_st.hic_cnt = st_ff.hic_len;
        nxt_st.ocp_cnt = cnt_inc;
      end else begin
        nxt_st.ocp_cnt = cnt_inc;
      end
    end

    // Clear on power-off.
    // A power-off also abandons any hiccup in progress.
    if (master_power_off_reset_nxt) begin
      nxt_st.ocp_cnt = 6'h00;
      nxt_st.ctl.hiccup = 1'b0;
      nxt_st.hic_cnt = 16'h0000;
    end

    // Cycle-by-cycle limit.
    // Below 2.4 V with headroom on the amplifier, only the cycle is cut.
    nxt_st.ctl.switch_node_off = st_ff.s2.preg_low & ~st_ff.s2.ea_max &
                                 st_ff.s2.hs_ilim;

    // Default oscillator.
    // This flag feeds nothing else, so power-good and latches stay clear.
    nxt_st.ctl.osc_default = st_ff.s2.freq_set_sync_fault;

    nxt_st.ctl.master_power_off_reset = master_power_off_reset_nxt;
    nxt_st.ctl.pump_undervoltage_flag = pump_uv_any;
    // Regulators run with ignition on and no power-off or overvoltage latch.
    nxt_st.ctl.regs_on = st_ff.s2.ignition_enable & ~master_power_off_reset_nxt & ~nxt_st.lat_ov;

    // Power-good from low rail.
    // In overcurrent the foldback only matters below the lower threshold.
    low_uv_eff = st_ff.s2.low_rail_oc ? st_ff.s2.low_rail_uv_low : st_ff.s2.low_rail_uv;
    // High rail excluded.
    // High rail and pre-regulator pin faults are only reported in status.
    nxt_st.ctl.power_good_reset_n = ~(low_uv_eff | nxt_st.lat_dio | nxt_st.lat_lx);

    // Status image, built from registered state only.
    status_word = 32'h0000_0000;
    status_word[RFS_ST_MASTER_POWER_OFF_RESET]     = st_ff.ctl.master_power_off_reset;
    status_word[RFS_ST_PG_N]     = st_ff.ctl.power_good_reset_n;
    status_word[RFS_ST_REGS_ON]  = st_ff.ctl.regs_on;
    status_word[RFS_ST_HICCUP]   = st_ff.ctl.hiccup;
    status_word[RFS_ST_LAT_DIO]  = st_ff.lat_dio;
    status_word[RFS_ST_LAT_LX]   = st_ff.lat_lx;
    status_word[RFS_ST_LAT_OV]   = st_ff.lat_ov;
    status_word[RFS_ST_PUMP_UV]  = st_ff.ctl.pump_undervoltage_flag;
    status_word[RFS_ST_OSC_DEF]  = st_ff.ctl.osc_default;
    status_word[RFS_ST_HIGH_UV]  = st_ff.s2.high_rail_uv;
    status_word[RFS_ST_HIGH_OC]  = st_ff.s2.high_rail_oc;
    status_word[RFS_ST_PREG_OPN] = st_ff.s2.preg_pin_open;
    status_word[RFS_ST_SW_OFF]   = st_ff.ctl.switch_node_off;

    // Write channels are taken independently and held until both are in.
    if (st_ff.awready && s_axi_awvalid) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.waddr = s_axi_awaddr;
    end
    if (st_ff.wready && s_axi_wvalid) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end

    // Only the control word is writable; read-only registers answer okay, unmapped addresses with an error.
    ctrl_new = st_ff.hic_len;
    if (st_ff.wstrb[0]) begin
      ctrl_new[7:0] = st_ff.wdata[7:0];
    end
    if (st_ff.wstrb[1]) begin
      ctrl_new[15:8] = st_ff.wdata[15:8];
    end
    if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      if (reg_idx(st_ff.waddr) == RFS_IDX_CTRL) begin
        nxt_st.hic_len = ctrl_new;
        nxt_st.bresp = RFS_RESP_OKAY;
      end else if (reg_idx(st_ff.waddr) == RFS_IDX_NONE) begin
        nxt_st.bresp = RFS_RESP_SLVERR;
      end else begin
        // Read-only registers ignore the data but accept the access.
        nxt_st.bresp = RFS_RESP_OKAY;
      end
    end else if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // A held channel stays closed until its write has been answered.
    nxt_st.awready = ~nxt_st.aw_got & ~nxt_st.bvalid;
    nxt_st.wready  = ~nxt_st.w_got & ~nxt_st.bvalid;

    // Read path answers one cycle after the address is taken.
    if (st_ff.arready && s_axi_arvalid) begin
      nxt_st.arready = 1'b0;
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = RFS_RESP_OKAY;
      case (reg_idx(s_axi_araddr))
        RFS_IDX_STATUS: nxt_st.rdata = status_word;
        RFS_IDX_CTRL:   nxt_st.rdata = {16'h0000, st_ff.hic_len};
        RFS_IDX_COUNT:  nxt_st.rdata = {26'h0000000, st_ff.ocp_cnt};
        default: begin
          nxt_st.rdata = 32'h0000_0000;
          nxt_st.rresp = RFS_RESP_SLVERR;
        end
      endcase
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
      nxt_st.arready = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  // The whole state resets to constants; regulators start off, power-good low.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff         <= '0;
      st_ff.hic_len <= RFS_HIC_LEN_RST;
      st_ff.awready <= 1'b1;
      st_ff.wready  <= 1'b1;
      st_ff.arready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops.

  assign ctl           = st_ff.ctl;
  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready  = st_ff.wready;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rdata   = st_ff.rdata;
  assign s_axi_rresp   = st_ff.rresp;
  assign s_axi_rvalid  = st_ff.rvalid;

endmodule : rfs_supervisor

// ===== bench/rfs_supervisor_chk.sv
// Port-level checker for the regulator fault supervisor, bound into its top module.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module rfs_supervisor_chk
  import rfs_pkg::*;
(
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rstn,
  // Pin flags and control outputs.
  input wire rfs_pins_t   pins,
  input wire rfs_ctl_t    ctl,
  // Bus handshakes.
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid
);
  logic [2:0] up_ff;    // Edges since reset, saturating.
  logic [2:0] nxt_up;   // Next edge count.
  logic       ok;       // The three-stage pin path holds post-reset values.
  logic       pump_any; // Any source of pump undervoltage.

  // The count keeps $past from reaching back into reset, where the flops were cleared.
  assign nxt_up   = (up_ff == 3'h7) ? up_ff : up_ff + 3'h1;
  assign ok       = (up_ff >= 3'h4);
  assign pump_any = pins.pump_uv | pins.pump_out_open | pins.pump_cap_open | pins.pump_cap1_gnd;

  // Edge counter register.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      up_ff <= 3'h0;
    end else begin
      up_ff <= nxt_up;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////////////
  // Diode fault seen with the supplies up, then the supplies stay up.
  sequence s_diode_seen;
    ok && pins.catch_diode_missing && pins.ignition_enable && pins.vin_ok;
  endsequence
  sequence s_supply_kept;
    (pins.ignition_enable && pins.vin_ok)[*6];
  endsequence
  // Joint write take.
  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  property p_pump_master_power_off_reset;
    ok && ($past(pins.pump_ov, 3) || $past(pump_any, 3)) |-> ctl.master_power_off_reset;
  endproperty
  a_pump_master_power_off_reset: assert property (p_pump_master_power_off_reset) else $error("pump fault without power-off reset");
  property p_uvflag;
    ok |-> ctl.pump_undervoltage_flag == $past(pump_any, 3);
  endproperty
  a_uvflag: assert property (p_uvflag) else $error("pump flag wrong");
  property p_osc;
    ok |-> ctl.osc_default == $past(pins.freq_set_sync_fault, 3);
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator default wrong");
  property p_diode_hold;
    s_diode_seen ##1 s_supply_kept |-> ctl.master_power_off_reset && !ctl.power_good_reset_n;
  endproperty
  a_diode_hold: assert property (p_diode_hold) else $error("diode fault not held");
  property p_lx;
    ok && $past(pins.switch_node_ilim, 3) |-> ctl.master_power_off_reset && !ctl.power_good_reset_n;
  endproperty
  a_lx: assert property (p_lx) else $error("switch node fault missed");
  property p_ov;
    ok && $past(pins.preg_ov, 3) |-> !ctl.regs_on;
  endproperty
  a_ov: assert property (p_ov) else $error("overvoltage left regulators on");
  property p_pg_low;
    ok && $past(pins.low_rail_uv, 3) && !$past(pins.low_rail_oc, 3) |-> !ctl.power_good_reset_n;
  endproperty
  a_pg_low: assert property (p_pg_low) else $error("power good high in undervoltage");
  property p_cut;
    ok && $past(pins.hs_ilim, 3) && $past(pins.preg_low, 3) && !$past(pins.ea_max, 3) |-> ctl.switch_node_off;
  endproperty
  a_cut: assert property (p_cut) else $error("cycle not cut");
  property p_read;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read: assert property (p_read) else $error("read answer late");
  property p_write;
    s_wtake |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_write: assert property (p_write) else $error("write answer late");
endmodule : rfs_supervisor_chk

bind rfs_supervisor rfs_supervisor_chk rfs_supervisor_chk_inst (.clk(clk), .rstn(rstn), .pins(pins),
  .ctl(ctl), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

// ===== bench/rfs_supervisor_bench.sv
// Self-checking bench for the regulator fault supervisor.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module rfs_supervisor_bench
  import rfs_pkg::*;
;
  // Quiet pins: supplies up, no faults.
  localparam rfs_pins_t BASE = '{ignition_enable: 1'b1, vin_ok: 1'b1, default: 1'b0};
  logic        clk, rstn, awv, wv, bre, arv, rre, awr, wr, bv, arr, rv;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdd, rd;
  logic [1:0]  br, rr, rs;
  rfs_pins_t   pins;
  rfs_ctl_t    ctl;
  int          errors, n_checks, i, n;

  rfs_supervisor rfs_supervisor_inst (.clk(clk), .rstn(rstn), .pins(pins), .ctl(ctl), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count.
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Wait n edges, then step past the edge so registered outputs have landed.
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  // Write: address and data offered together, each dropped once taken.
  task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int t;
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1; t = 0;
    do begin
      @(posedge clk); t++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (!bv && t < 50);
    r = br; bre <= 1'b0;
    if (t >= 50) errors++;
  endtask : axw
  // Read: rready held until the data is sampled.
  task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    @(posedge clk);
    ara <= a; arv <= 1'b1; rre <= 1'b1; t = 0;
    do begin
      @(posedge clk); t++;
      if (arv && arr) arv <= 1'b0;
    end while (!rv && t < 50);
    d = rdd; r = rr; rre <= 1'b0;
    if (t >= 50) errors++;
  endtask : axr
  // Overcurrent pulses, one cycle high and one low each.
  task pulse_oc(input int k);
    repeat (k) begin
      @(posedge clk); pins.overcurrent_event <= 1'b1;
      @(posedge clk); pins.overcurrent_event <= 1'b0;
    end
  endtask : pulse_oc

  ////////////////////////////////////////////////////////////////////////////////
  // Register map: reset value, read-only writes, unmapped and misaligned places.
  task t_regs;
    axr(RFS_ADDR_CTRL, rd, rs); chk(rd, 32'h0000_0400);
    axw(RFS_ADDR_CTRL, 32'h0000_0010, rs); chk({30'h0, rs}, {30'h0, RFS_RESP_OKAY});
    axr(RFS_ADDR_CTRL, rd, rs); chk(rd, 32'h0000_0010);
    axw(RFS_ADDR_COUNT, 32'h0000_003f, rs); chk({30'h0, rs}, {30'h0, RFS_RESP_OKAY});
    axr(RFS_ADDR_COUNT, rd, rs); chk(rd, 32'h0);
    axw(8'h0c, 32'h0000_0001, rs); chk({30'h0, rs}, {30'h0, RFS_RESP_SLVERR});
    axr(8'h0c, rd, rs); chk({rd[29:0], rs}, {30'h0, RFS_RESP_SLVERR});
    axr(8'h02, rd, rs); chk({30'h0, rs}, {30'h0, RFS_RESP_SLVERR});
    $display("test regs done");
  endtask : t_regs
  // Hiccup threshold, off-time of 16 cycles, counter cleared afterwards.
  task t_hic(input logic low, input int lim);
    @(posedge clk); pins <= BASE; pins.preg_low <= low; pins.ea_max <= 1'b1;
    pulse_oc(lim - 1); wt(6);
    chk(ctl.hiccup, 1'b0);
    axr(RFS_ADDR_COUNT, rd, rs); chk(rd, lim - 1);
    pulse_oc(1); wt(1); n = 0;
    while (ctl.hiccup !== 1'b1 && n < 10) begin wt(1); n++; end
    chk(ctl.hiccup, 1'b1);
    n = 0;
    while (ctl.hiccup === 1'b1 && n < 40) begin wt(1); n++; end
    chk(n, 16);
    axr(RFS_ADDR_COUNT, rd, rs); chk(rd, 32'h0);
    $display("test hiccup done");
  endtask : t_hic
  // Low output, amplifier unsaturated: cycle cut, events ignored, nothing latched.
  task t_cut;
    @(posedge clk); pins <= BASE; pins.preg_low <= 1'b1; pins.hs_ilim <= 1'b1;
    pulse_oc(3); wt(4);
    chk({ctl.switch_node_off, ctl.master_power_off_reset, ctl.regs_on}, 3'b101);
    axr(RFS_ADDR_COUNT, rd, rs); chk(rd, 32'h0);
    @(posedge clk); pins <= BASE; wt(4);
    chk({ctl.switch_node_off, ctl.master_power_off_reset}, 2'b00);
    $display("test cut done");
  endtask : t_cut
  // Every pump fault source trips the unlatched power-off reset.
  task t_pump;
    for (i = 0; i < 5; i++) begin
      @(posedge clk);
      case (i)
        0: pins.pump_ov <= 1'b1;
        1: pins.pump_uv <= 1'b1;
        2: pins.pump_out_open <= 1'b1;
        3: pins.pump_cap_open <= 1'b1;
        default: pins.pump_cap1_gnd <= 1'b1;
      endcase
      wt(4);
      chk({ctl.master_power_off_reset, ctl.pump_undervoltage_flag}, {1'b1, i != 0});
      @(posedge clk); pins <= BASE; wt(6);
      chk({ctl.master_power_off_reset, ctl.regs_on}, 2'b01);
    end
    $display("test pump done");
  endtask : t_pump
  // Frequency pin and high rail faults leave power good and latch nothing.
  task t_misc;
    @(posedge clk); pins.freq_set_sync_fault <= 1'b1; pins.high_rail_uv <= 1'b1;
    pins.high_rail_oc <= 1'b1; pins.preg_pin_open <= 1'b1; wt(4);
    chk({ctl.osc_default, ctl.power_good_reset_n, ctl.master_power_off_reset}, 3'b110);
    axr(RFS_ADDR_STATUS, rd, rs); chk(rd[11:9], 3'b111);
    @(posedge clk); pins <= BASE; wt(4);
    chk({ctl.osc_default, ctl.power_good_reset_n, ctl.regs_on}, 3'b011);
    $display("test misc done");
  endtask : t_misc
  // Power good on the low rail, with the overcurrent threshold switch.
  task t_low;
    @(posedge clk); pins.low_rail_uv <= 1'b1; wt(4);
    chk(ctl.power_good_reset_n, 1'b0);
    @(posedge clk); pins.low_rail_oc <= 1'b1; wt(4);
    chk(ctl.power_good_reset_n, 1'b1);
    @(posedge clk); pins.low_rail_uv_low <= 1'b1; wt(4);
    chk(ctl.power_good_reset_n, 1'b0);
    @(posedge clk); pins <= BASE; wt(4);
    $display("test low rail done");
  endtask : t_low
  // One-cycle faults latch until ignition or input supply is cycled.
  task t_latch;
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      case (i)
        0: pins.catch_diode_missing <= 1'b1;
        1: pins.switch_node_ilim <= 1'b1;
        default: pins.preg_ov <= 1'b1;
      endcase
      @(posedge clk); pins <= BASE; wt(8);
      chk({ctl.regs_on, ctl.master_power_off_reset, ctl.power_good_reset_n}, {1'b0, i < 2, i == 2});
      axr(RFS_ADDR_STATUS, rd, rs); chk(rd[RFS_ST_LAT_DIO + i], 1'b1);
      @(posedge clk);
      if (i == 2) pins.vin_ok <= 1'b0;
      else pins.ignition_enable <= 1'b0;
      @(posedge clk); pins <= BASE; wt(8);
      chk({ctl.regs_on, ctl.master_power_off_reset, ctl.power_good_reset_n}, 3'b101);
    end
    $display("test latch done");
  endtask : t_latch
  // Counts, verdict and end of run.
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Watchdog, well beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    final_report();
  end
  // Main sequence.
  initial begin
    rstn = 1'b0; pins = BASE; awv = 1'b0; wv = 1'b0; bre = 1'b0; arv = 1'b0; rre = 1'b0;
    awa = 8'h00; ara = 8'h00; wd = 32'h0; errors = 0; n_checks = 0;
    wt(5); chk({25'h0, ctl}, 32'h0);
    @(posedge clk); rstn <= 1'b1;
    wt(4);
    t_regs(); t_hic(1'b1, 15); t_hic(1'b0, 60); t_cut(); t_pump(); t_misc(); t_low(); t_latch();
    final_report();
  end
endmodule : rfs_supervisor_bench
